// File: io_pkg.sv
// constants shared by the machine i/o block: register indices, field
// positions, reset values and the state encoding of the output stage.
// assumes a 32-bit apb with byte addresses; each register is one word.
`default_nettype none
package io_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 6;
   localparam int BYTE_W = 8;
   localparam int IDX_LSB = 2;
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] REG_IDX_IN_SPACE = 6'h1_0;
   localparam logic [IDX_W-1:0] REG_IDX_FAULT    = 6'h0_f;
   localparam logic [IDX_W-1:0] REG_IDX_DOUT     = 6'h1_0;
   localparam logic [IDX_W-1:0] REG_IDX_CTRL     = 6'h1_1;
   localparam logic [IDX_W-1:0] REG_IDX_INT_STAT = 6'h1_2;
   localparam logic [IDX_W-1:0] REG_IDX_INT_MASK = 6'h1_3;
   localparam logic [IDX_W-1:0] REG_IDX_STATUS   = 6'h1_4;
   // selectable-common input bytes
   localparam int SEL_BYTE0 = 0;
   localparam int SEL_BYTE5 = 5;
   // fault flag byte: bits 0..6 map to output bytes, bit 7 reserved
   localparam logic [BYTE_W-1:0] FAULT_VALID_MASK = 8'h7f;
   // control and status fields
   localparam int CTRL_PG_SEL_BIT = 0;
   localparam logic CTRL_PG_SEL_RST = 1'b0;
   localparam int STAT_COM0_BIT = 0;
   localparam int STAT_COM5_BIT = 1;
   localparam int STAT_OFF_BIT  = 2;
   localparam int STAT_PG_BIT   = 3;
   localparam int INT_SHUT_BIT  = 7;
   localparam logic [BYTE_W-1:0] INT_MASK_RST = 8'h00;
   localparam int SYNC_STAGES = 3;
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_OFF = 2'b10
   } out_state_t;
endpackage
`default_nettype wire

// File: pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs.
// assumes inputs are asynchronous to clk; a change is taken once
// the second and third stages agree.
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] level_q;
   wire  [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
   wire  [WIDTH-1:0] level_d = (s2_q & agree) | (level_q & ~agree);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         level_q <= '0;
      end else begin
         s1_q    <= pin;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         level_q <= level_d;
      end
   end

   assign level = level_q;
endmodule
`default_nettype wire

// File: io_module_output_fault_input_polarity.sv
// digital core of a 48-in / 32-out machine i/o module: input polarity,
// per-byte driver protection, fault flag byte and apb register access.
// assumes one clock pclk, async active-low presetn, all pins async.
`default_nettype none
module io_module_output_fault_input_polarity
   import io_pkg::*;
#(
   parameter int IN_BYTES      = 6,
   parameter int OUT_BYTES     = 4,
   parameter bit HAS_PULSE_GEN = 1'b1
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ADDR_W-1:0]      paddr,
   input  wire logic [DATA_W-1:0]      pwdata,
   output logic      [DATA_W-1:0]      prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [IN_BYTES*8-1:0]  din_pin,
   input  wire logic                   input_byte0_common_select,
   input  wire logic                   input_byte5_common_select,
   input  wire logic [OUT_BYTES-1:0]   driver_fault,
   input  wire logic                   system_alarm,
   input  wire logic                   link_fail,
   output logic      [OUT_BYTES*8-1:0] dout,
   output logic                        manual_pulse_generator_active,
   output logic                        irq
);
   localparam int IW = IN_BYTES * 8;
   localparam int OW = OUT_BYTES * 8;
   localparam int SW = IW + 2 + OUT_BYTES + 2;

   // pin synchronisation
   logic [SW-1:0]        sync_level;
   logic [IW-1:0]        din_s;
   logic                 com0_s;
   logic                 com5_s;
   logic [OUT_BYTES-1:0] fault_s;
   logic                 alarm_s;
   logic                 linkf_s;

   pin_sync #(
      .WIDTH (SW)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .pin   ({link_fail, system_alarm, driver_fault,
               input_byte5_common_select, input_byte0_common_select, din_pin}),
      .level (sync_level)
   );

   assign din_s   = sync_level[IW-1:0];
   assign com0_s  = sync_level[IW];
   assign com5_s  = sync_level[IW+1];
   assign fault_s = sync_level[IW+2 +: OUT_BYTES];
   assign alarm_s = sync_level[IW+2+OUT_BYTES];
   assign linkf_s = sync_level[IW+3+OUT_BYTES];

   // input image; a floating input reads zero at the pin, so the
   // xor alone gives zero on fixed bytes and the common level on
   // selectable bytes
   // an open select is sampled at whatever level the pin floats to,
   // so unused inputs of that byte are then undefined
   wire [IW-1:0] invert_mask;
   wire [IW-1:0] din_image;
   wire [OW-1:0] fault_bytes;

   genvar gb;
   generate
      for (gb = 0; gb < IN_BYTES; gb++) begin : g_in
         assign invert_mask[gb*8 +: 8] =
            (gb == SEL_BYTE0) ? {8{com0_s}} :
            (gb == SEL_BYTE5) ? {8{com5_s}} :
            8'h00;
      end
      for (gb = 0; gb < OUT_BYTES; gb++) begin : g_out
         assign fault_bytes[gb*8 +: 8] = {8{fault_s[gb]}};
      end
   endgenerate

   assign din_image = din_s ^ invert_mask;

   // fault flags follow the driver level directly, so a flag drops as
   // soon as protection releases; nothing software writes reaches them
   wire [BYTE_W-1:0] fault_flags =
      BYTE_W'(fault_s) & FAULT_VALID_MASK;

   // output stage state
   out_state_t st_q;
   out_state_t st_d;
   wire        shut = alarm_s | linkf_s;

   always_comb begin
      case (st_q)
         ST_RUN:  st_d = shut ? ST_OFF : ST_RUN;
         ST_OFF:  st_d = shut ? ST_OFF : ST_RUN;
         default: st_d = ST_OFF;
      endcase
   end

   // apb decode
   logic [DATA_W-1:0]    prdata_q;
   logic                 pready_q;
   logic                 pslverr_q;
   logic [OW-1:0]        out_q;
   logic                 pg_sel_q;
   logic [BYTE_W-1:0]    int_stat_q;
   logic [BYTE_W-1:0]    int_mask_q;
   logic [OUT_BYTES-1:0] fault_prev_q;
   logic [OW-1:0]        dout_q;
   logic                 pg_active_q;
   logic                 irq_q;

   wire             setup   = psel & ~penable;
   wire             access  = psel & penable & pready_q;
   wire             wr_en   = access & pwrite;
   wire [IDX_W-1:0] idx     = paddr[ADDR_W-1:IDX_LSB];
   wire             hit_in  = idx < REG_IDX_IN_SPACE;
   wire             hit_din = idx < IDX_W'(IN_BYTES);
   wire [2:0]       idx_in  = idx[2:0];
   wire             hit_out = idx == REG_IDX_DOUT;
   wire             hit_ctl = idx == REG_IDX_CTRL;
   wire             hit_ist = idx == REG_IDX_INT_STAT;
   wire             hit_imk = idx == REG_IDX_INT_MASK;
   wire             hit_sts = idx == REG_IDX_STATUS;
   wire             hit     = hit_in | hit_out | hit_ctl | hit_ist | hit_imk | hit_sts;

   wire [BYTE_W-1:0] status_byte = {4'h0, pg_active_q, st_q == ST_OFF, com5_s, com0_s};

   wire [DATA_W-1:0] rd_mux =
      (hit_din)                ? DATA_W'(din_image[idx_in*8 +: 8]) :
      (idx == REG_IDX_FAULT)   ? DATA_W'(fault_flags) :
      (hit_out)                ? DATA_W'(out_q) :
      (hit_ctl)                ? DATA_W'(pg_sel_q) :
      (hit_ist)                ? DATA_W'(int_stat_q) :
      (hit_imk)                ? DATA_W'(int_mask_q) :
      (hit_sts)                ? DATA_W'(status_byte) :
      '0;

   // writes into input space are dropped silently
   wire wr_out = wr_en & hit_out;
   wire wr_ctl = wr_en & hit_ctl;
   wire wr_ist = wr_en & hit_ist;
   wire wr_imk = wr_en & hit_imk;

   // events: a driver entering protection, outputs forced off
   wire [BYTE_W-1:0] ev_fault = BYTE_W'(fault_s & ~fault_prev_q);
   wire [BYTE_W-1:0] ev_shut  =
      (st_q == ST_RUN && st_d == ST_OFF) ? (8'h01 << INT_SHUT_BIT) : 8'h00;
   wire [BYTE_W-1:0] w1c      = wr_ist ? pwdata[BYTE_W-1:0] : 8'h00;
   wire [BYTE_W-1:0] int_stat_d = (int_stat_q & ~w1c) | ev_fault | ev_shut;

   // each byte is gated only by its own driver; shutdown gates all
   wire [OW-1:0] dout_d =
      (st_q == ST_RUN) ? (out_q & ~fault_bytes) : '0;

   wire pg_active_d = HAS_PULSE_GEN & pg_sel_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~hit;
         if (setup) begin
            prdata_q <= pwrite ? '0 : rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q      <= '0;
         pg_sel_q   <= CTRL_PG_SEL_RST;
         int_mask_q <= INT_MASK_RST;
      end else begin
         if (wr_out) begin
            out_q <= pwdata[OW-1:0];
         end
         if (wr_ctl) begin
            pg_sel_q <= pwdata[CTRL_PG_SEL_BIT];
         end
         if (wr_imk) begin
            int_mask_q <= pwdata[BYTE_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q         <= ST_RUN;
         int_stat_q   <= '0;
         fault_prev_q <= '0;
         dout_q       <= '0;
         pg_active_q  <= 1'b0;
         irq_q        <= 1'b0;
      end else begin
         st_q         <= st_d;
         int_stat_q   <= int_stat_d;
         fault_prev_q <= fault_s;
         dout_q       <= dout_d;
         pg_active_q  <= pg_active_d;
         irq_q        <= |(int_stat_d & int_mask_q);
      end
   end

   assign prdata                        = prdata_q;
   assign pready                        = pready_q;
   assign pslverr                       = pslverr_q;
   assign dout                          = dout_q;
   assign manual_pulse_generator_active = pg_active_q;
   assign irq                           = irq_q;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_rd_setup(logic [IDX_W-1:0] i);
      setup && !pwrite && idx == i;
   endsequence

   sequence s_running;
      st_q == ST_RUN && !shut;
   endsequence

   property p_fault_off;
      (|fault_s) |=> ((dout & $past(fault_bytes)) == '0);
   endproperty
   a_fault_off: assert property (p_fault_off)
      else $error("faulted byte not held off");

   property p_other_bytes;
      st_q == ST_RUN |=> (dout == ($past(out_q) & ~$past(fault_bytes)));
   endproperty
   a_other_bytes: assert property (p_other_bytes)
      else $error("healthy byte disturbed by fault");

   property p_fault_read;
      s_rd_setup(REG_IDX_FAULT) |=>
         pready && prdata == DATA_W'($past(fault_s) & OUT_BYTES'(FAULT_VALID_MASK))
         && prdata[BYTE_W-1] == 1'b0;
   endproperty
   a_fault_read: assert property (p_fault_read)
      else $error("fault flag read wrong");

   property p_flag_clears;
      s_running ##1 (!fault_s[0] && fault_prev_q[0]) |=>
         dout[7:0] == $past(out_q[7:0]);
   endproperty
   a_flag_clears: assert property (p_flag_clears)
      else $error("byte did not resume after release");

   property p_invert;
      s_rd_setup(IDX_W'(SEL_BYTE0)) |=>
         prdata[7:0] == ($past(din_s[7:0]) ^ {8{$past(com0_s)}});
   endproperty
   a_invert: assert property (p_invert)
      else $error("selectable byte polarity wrong");

   property p_fixed;
      s_rd_setup(6'h0_1) |=> prdata[7:0] == $past(din_s[15:8]);
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed byte not passed straight");

   property p_shutdown;
      shut |=> st_q == ST_OFF ##1 dout == '0;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("outputs not forced off on alarm");

   property p_ro;
      (wr_en && idx == REG_IDX_FAULT) |=> $stable(out_q) && $stable(int_mask_q);
   endproperty
   a_ro: assert property (p_ro)
      else $error("write to fault flags had an effect");

   property p_pg;
      pg_active_q |-> HAS_PULSE_GEN && $past(pg_sel_q);
   endproperty
   a_pg: assert property (p_pg)
      else $error("pulse generator active without selection");

   property p_set_wins;
      (ev_fault[0] && w1c[0]) |=> int_stat_q[0];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost on clear");
endmodule
`default_nettype wire

// File: nc_bus_master.sv
// controller-side apb master model for the i/o block's register bus.
// assumes shared pclk/presetn; tasks are entered at a rising edge.
`default_nettype none
module nc_bus_master
   import io_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   output var  logic              psel,
   output var  logic              penable,
   output var  logic              pwrite,
   output var  logic [ADDR_W-1:0] paddr,
   output var  logic [DATA_W-1:0] pwdata,
   input  wire logic [DATA_W-1:0] prdata,
   input  wire logic              pready,
   input  wire logic              pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // waits up to 64 extra edges for pready; the extra idle edge keeps two calls from
   // assigning psel twice in one time step
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r,
                       output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 64) begin
         n++;
         @(posedge pclk);
      end
      if (pready !== 1'b1) begin
         tb_io_module_output_fault_input_polarity.timeout();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// File: tb_io_module_output_fault_input_polarity.sv
// self-checking bench for the machine i/o block: apb tasks plus pin drive.
// assumes the partner master model and the design's package.
`default_nettype none
module tb_io_module_output_fault_input_polarity;
   import io_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic [47:0]       din_pin;
   logic              input_byte0_common_select;
   logic              input_byte5_common_select;
   logic [3:0]        driver_fault;
   logic              system_alarm;
   logic              link_fail;
   logic [31:0]       dout;
   logic              manual_pulse_generator_active;
   logic              irq;
   int                fails;
   int                cmp_count;
   logic [DATA_W-1:0] r;
   logic              e;

   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   nc_bus_master nc_bus_master_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   io_module_output_fault_input_polarity #(.IN_BYTES(6), .OUT_BYTES(4), .HAS_PULSE_GEN(1'b1))
   io_module_output_fault_input_polarity_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .din_pin(din_pin),
      .input_byte0_common_select(input_byte0_common_select),
      .input_byte5_common_select(input_byte5_common_select),
      .driver_fault(driver_fault), .system_alarm(system_alarm), .link_fail(link_fail),
      .dout(dout), .manual_pulse_generator_active(manual_pulse_generator_active),
      .irq(irq));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic timeout();
      fails++;
      $display("mismatch at %0t: bus wait ran out", $time);
      end_of_test();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string m);
      chk({31'h0, got}, {31'h0, exp}, m);
   endtask

   task automatic rd(input logic [IDX_W-1:0] i, input logic [31:0] exp, input logic err);
      nc_bus_master_inst.xfer(1'b0, {i, 2'b00}, '0, r, e);
      chk(r, exp, "read data");
      chk1(e, err, "slave error");
   endtask

   task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
      nc_bus_master_inst.xfer(1'b1, {i, 2'b00}, d, r, e);
      chk1(e, 1'b0, "write error");
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   function automatic logic [31:0] exp_in(input int b);
      logic [7:0] v;
      v = din_pin[b*8 +: 8];
      if (b == SEL_BYTE0 && input_byte0_common_select) v = ~v;
      if (b == SEL_BYTE5 && input_byte5_common_select) v = ~v;
      return {24'h00_0000, v};
   endfunction

   // walks the whole sixteen-entry input block as the controller must map it
   task automatic scan(input logic [7:0] flt);
      for (int b = 0; b < 16; b++) begin
         if (b < 6) rd(6'(b), exp_in(b), 1'b0);
         else if (b < 15) rd(6'(b), 32'h0000_0000, 1'b0);
         else rd(REG_IDX_FAULT, {24'h00_0000, flt}, 1'b0);
      end
   endtask

   initial begin
      fails = 0;
      cmp_count = 0;
      presetn = 1'b0;
      din_pin = '0;
      input_byte0_common_select = 1'b0;
      input_byte5_common_select = 1'b0;
      driver_fault = '0;
      system_alarm = 1'b0;
      link_fail = 1'b0;
      tick(3);
      presetn <= 1'b1;
      tick(1);
      rd(REG_IDX_DOUT, 32'h0000_0000, 1'b0);
      rd(REG_IDX_CTRL, 32'h0000_0000, 1'b0);
      rd(REG_IDX_INT_MASK, {24'h00_0000, INT_MASK_RST}, 1'b0);
      rd(REG_IDX_INT_STAT, 32'h0000_0000, 1'b0);
      rd(6'h3f, 32'h0000_0000, 1'b1);
      $display("test reset finished");
      // stop input kept on fixed-common byte 1 bit 4 in the pattern
      for (int s = 0; s < 4; s++) begin
         input_byte0_common_select <= s[0];
         input_byte5_common_select <= s[0] ^ s[1];
         din_pin <= s[1] ? 48'h5a3c_0f12_91e7 : 48'h0000_0000_0000;
         tick(8);
         scan(8'h00);
      end
      $display("test polarity finished");
      wr(REG_IDX_DOUT, 32'hc3a5_5a3c);
      tick(2);
      chk(dout, 32'hc3a5_5a3c, "dout");
      driver_fault <= 4'b0101;
      tick(8);
      chk(dout, 32'hc300_5a00, "faulted bytes");
      chk1(irq, 1'b0, "masked irq");
      scan(8'h05);
      wr(REG_IDX_FAULT, 32'h0000_00ff);
      rd(REG_IDX_FAULT, 32'h0000_0005, 1'b0);
      rd(REG_IDX_INT_STAT, 32'h0000_0005, 1'b0);
      wr(REG_IDX_INT_MASK, 32'h0000_0004);
      tick(2);
      chk1(irq, 1'b1, "irq unmasked");
      wr(REG_IDX_INT_STAT, 32'h0000_0005);
      tick(2);
      chk1(irq, 1'b0, "irq cleared");
      rd(REG_IDX_INT_STAT, 32'h0000_0000, 1'b0);
      driver_fault <= 4'b0000;
      tick(8);
      chk(dout, 32'hc3a5_5a3c, "bytes resumed");
      rd(REG_IDX_FAULT, 32'h0000_0000, 1'b0);
      // fault rises 4 edges after the pin; the clear lands on the next edge, the one that latches the event
      driver_fault <= 4'b0001;
      tick(3);
      wr(REG_IDX_INT_STAT, 32'h0000_0001);
      rd(REG_IDX_INT_STAT, 32'h0000_0001, 1'b0);
      driver_fault <= 4'b0000;
      tick(8);
      wr(REG_IDX_INT_STAT, 32'h0000_0001);
      rd(REG_IDX_INT_STAT, 32'h0000_0000, 1'b0);
      $display("test fault finished");
      wr(REG_IDX_INT_MASK, 32'h0000_0080);
      for (int k = 0; k < 2; k++) begin
         system_alarm <= (k == 0);
         link_fail <= (k == 1);
         tick(8);
         chk(dout, 32'h0000_0000, "forced off");
         chk1(irq, 1'b1, "shutdown irq");
         rd(REG_IDX_STATUS, 32'h0000_0005, 1'b0);
         system_alarm <= 1'b0;
         link_fail <= 1'b0;
         tick(8);
         chk(dout, 32'hc3a5_5a3c, "outputs resumed");
         wr(REG_IDX_INT_STAT, 32'h0000_0080);
         tick(2);
         chk1(irq, 1'b0, "shutdown irq cleared");
      end
      $display("test shutdown finished");
      wr(REG_IDX_CTRL, 32'h0000_0001);
      tick(1);
      chk1(manual_pulse_generator_active, 1'b1, "pulse generator");
      rd(REG_IDX_STATUS, 32'h0000_0009, 1'b0);
      rd(REG_IDX_CTRL, 32'h0000_0001, 1'b0);
      $display("test pulse generator finished");
      end_of_test();
   end
endmodule
`default_nettype wire
